// *** src/tem_pkg.sv ***
package tem_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int SEC_MS = 1000;
  localparam int SEC_CYC = SEC_MS * 1000 * CLK_MHZ;
  localparam int FRAME_US = 125;
  localparam int YEL_WIN_MS = 48;
  localparam logic [8:0] YEL_WIN_FRM = 9'(YEL_WIN_MS * 1000 / FRAME_US);
  localparam int AIS_WIN_MS = 3;
  localparam logic [8:0] AIS_WIN_FRM = 9'(AIS_WIN_MS * 1000 / FRAME_US);

  // ---------------------------------------------------------------
  // Alarm thresholds and positions
  // ---------------------------------------------------------------
  localparam logic [3:0] YEL_ONES_MAX = 4'h2;
  localparam logic [3:0] YEL_SAT = 4'hF;
  localparam logic [2:0] AIS_MIN_ZEROS = 3'h6;
  localparam logic [7:0] LOS_LONG = 8'hC0;
  localparam logic [7:0] LOS_SHORT = 8'h20;
  localparam logic [7:0] ZRUN_SAT = 8'hFF;
  localparam logic [15:0] CW_T1 = 16'h00FF;
  localparam logic [15:0] CW_J1 = 16'hFFFF;
  localparam int CW_HIST = 10;
  localparam logic [3:0] CW_LAST = 4'hF;
  localparam logic [3:0] CW_MIN = 4'h8;
  localparam logic [4:0] TS0 = 5'h00;
  localparam logic [4:0] TS_DM = 5'h17;
  localparam logic [4:0] TS16 = 5'h10;
  localparam logic [2:0] POS_FIRST = 3'h0;
  localparam logic [2:0] POS_BIT2 = 3'h1;
  localparam logic [2:0] POS_RAI = 3'h2;
  localparam logic [2:0] POS_Y = 3'h5;
  localparam logic [2:0] POS_LAST = 3'h7;
  localparam logic [3:0] FRM_S12 = 4'hB;
  localparam logic [3:0] FRM_MFAS = 4'h0;
  localparam logic [1:0] AIS_DF_ONE = 2'h1;
  localparam logic [1:0] AIS_DF_TWO = 2'h2;

  // ---------------------------------------------------------------
  // Counters and injection commands
  // ---------------------------------------------------------------
  localparam int NCNT = 9;
  localparam int CNT_DW = 16;
  localparam int NINJ = 7;
  localparam int INJ_BPV = 0;
  localparam int INJ_CRC = 1;
  localparam int INJ_FBIT = 2;
  localparam int INJ_PAY = 3;
  localparam int INJ_LOS = 4;
  localparam int INJ_EBIT = 5;
  localparam int INJ_NFAS = 6;

  typedef enum logic [2:0] {TEM_D4, TEM_ESF, TEM_J1ESF, TEM_T1DM, TEM_E1} tem_mode_t;

  typedef struct packed {
    tem_mode_t mode;
    logic los_short;
    logic ais_alt;
    logic yel_s12;
    logic latch_en;
  } tem_cfg_t;

  typedef struct packed {
    logic vld;
    logic bit_v;
    logic sof;
    logic fbit;
    logic dl;
    logic [3:0] frm;
    logic [4:0] ts;
    logic [2:0] pos;
  } tem_rx_t;

  typedef struct packed {
    logic vld;
    logic bit_v;
    logic sof;
    logic fbit;
    logic crc;
    logic ebit;
    logic nfas;
    logic pay;
  } tem_tx_t;

  typedef struct packed {
    logic vld;
    logic bit_v;
    logic bpv;
  } tem_txo_t;

  typedef struct packed {
    logic yel;
    logic ais;
    logic los;
    logic rai;
    logic ts16_ais;
    logic mf_yel;
  } tem_alm_t;

  typedef logic [NCNT-1:0][CNT_DW-1:0] tem_cnt_arr_t;

  function automatic int cnt_w(input int idx);
    cnt_w = (idx >= 2 && idx <= 5) ? 16 : 8;
  endfunction

endpackage

// *** src/tem_sync.sv ***
module tem_sync #(
  parameter int W = 1
) (
  // Destination clock
  input wire logic clk,
  input wire logic srst,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } tem_sync_st_t;

  tem_sync_st_t st_ff;
  tem_sync_st_t nxt_st;

  // The first stage feeds only the second.
  always_comb begin
    nxt_st.s1 = d;
    nxt_st.s2 = st_ff.s1;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign q = st_ff.s2;

endmodule

// *** src/tem_cnt.sv ***
module tem_cnt #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Count and software access
  input wire logic inc,
  input wire logic wr,
  input wire logic [tem_pkg::CNT_DW-1:0] wr_val,
  input wire logic snap,
  // Results
  output logic [tem_pkg::CNT_DW-1:0] q,
  output logic [tem_pkg::CNT_DW-1:0] q_snap,
  output logic occ,
  output logic ovf
);
  import tem_pkg::*;

  if (W < 1 || W > CNT_DW) begin : g_chk
    $error("Counter width out of range.");
  end

  typedef struct packed {
    logic [W-1:0] val;
    logic [W-1:0] snp;
  } tem_cnt_st_t;

  tem_cnt_st_t st_ff;
  tem_cnt_st_t nxt_st;

  // A software write in the same cycle as an event wins; that event is not counted.
  always_comb begin
    nxt_st = st_ff;
    if (wr) begin
      nxt_st.val = wr_val[W-1:0];
    end else if (inc) begin
      nxt_st.val = st_ff.val + 1'b1;
    end
    if (snap) begin
      nxt_st.snp = st_ff.val;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign q = CNT_DW'(st_ff.val);
  assign q_snap = CNT_DW'(st_ff.snp);
  assign occ = inc && !wr;
  assign ovf = inc && !wr && (&st_ff.val);

endmodule

// *** src/tem_alarm_mon.sv ***
// Behaviour
// - D4: yellow when bit 2 is zero in nearly all channel bytes over 48 ms.
// - D4: optional yellow on two consecutive ones in frame-12 S-bit.
// - T1 ESF: yellow when codeword 0000000011111111 seen in 8 of 10.
// - J1 ESF: yellow when all-ones codeword seen in 8 of 10.
// - T1DM: yellow while bit 2 of the sync byte is zero.
// - T1/J1: AIS when fewer than six zeros arrive in 3 ms.
// - Loss of signal after 192 or 32 consecutive zeros, selectable.
// - E1: remote alarm follows bit 3 of the received NFAS.
// - E1: AIS on unframed all ones for one or two double frames.
// - E1: timeslot 16 AIS when timeslot 16 carries all ones.
// - E1: multiframe remote alarm follows Y-bit of the MFAS.
// - Software may clear or preset any error counter by writing it.
// - Counters optionally latched once per second for stable reading.
// - T1/J1 counter set with 8-bit and 16-bit widths.
// - E1 counter set with 8-bit and 16-bit widths.
// - Inject BPV, CRC, framing, payload and LOS errors on command; E-bit and NFAS errors in E1 only.
module tem_alarm_mon #(
  parameter int SEC_CYC = tem_pkg::SEC_CYC
) (
  // System clock domain
  input wire logic clk,
  input wire logic srst,
  input wire tem_pkg::tem_cfg_t cfg,
  // Line clock domain
  input wire logic lclk,
  input wire tem_pkg::tem_rx_t rx,
  input wire logic [tem_pkg::NCNT-1:0] err_ev,
  input wire tem_pkg::tem_tx_t tx_in,
  output tem_pkg::tem_txo_t tx_out,
  // Error injection commands
  input wire logic [tem_pkg::NINJ-1:0] inj_req,
  // Counter access
  input wire logic [tem_pkg::NCNT-1:0] cnt_wr,
  input wire logic [tem_pkg::CNT_DW-1:0] cnt_wr_val,
  output tem_pkg::tem_cnt_arr_t cnt_q,
  // Event flags
  input wire logic [tem_pkg::NCNT-1:0] occ_clr,
  input wire logic [tem_pkg::NCNT-1:0] ovf_clr,
  input wire logic [tem_pkg::NCNT-1:0] occ_mask,
  input wire logic [tem_pkg::NCNT-1:0] ovf_mask,
  output logic [tem_pkg::NCNT-1:0] occ_flag,
  output logic [tem_pkg::NCNT-1:0] ovf_flag,
  // Alarms
  output tem_pkg::tem_alm_t alm
);
  import tem_pkg::*;

  if (SEC_CYC < 2) begin : g_chk
    $error("SEC_CYC must be at least 2.");
  end

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [NCNT-1:0] ev_tgl;
    logic [NINJ-1:0] inj_d;
    logic [NINJ-1:0] inj_pend;
    logic los_act;
    tem_txo_t tx;
    logic [7:0] zrun;
    logic los;
    logic [8:0] y_frm;
    logic [3:0] y_ones;
    logic yel1;
    logic s12_prev;
    logic yel2;
    logic [15:0] cw_sr;
    logic [3:0] cw_bits;
    logic [CW_HIST-1:0] cw_hist;
    logic yel_cw;
    logic yel_dm;
    logic [8:0] a_frm;
    logic [2:0] a_zero;
    logic ais_t1;
    logic d_zero;
    logic [1:0] d_ok;
    logic rai;
    logic t16_z;
    logic t16_ais;
    logic mfy;
    tem_alm_t alm;
  } tem_lk_st_t;

  typedef struct packed {
    logic [NCNT-1:0] ev_d;
    logic [NINJ-1:0] inj_tgl;
    logic [31:0] sec;
    logic [NCNT-1:0] occ;
    logic [NCNT-1:0] ovf;
  } tem_sy_st_t;

  tem_lk_st_t lk_ff;
  tem_lk_st_t nxt_lk;
  tem_sy_st_t sy_ff;
  tem_sy_st_t nxt_sy;

  logic lk_rst;
  logic [$bits(tem_cfg_t)-1:0] cfg_lv;
  tem_cfg_t cfg_l;
  logic [NINJ-1:0] inj_s;
  logic [NCNT-1:0] ev_s;
  tem_alm_t alm_s;
  logic [NCNT-1:0] ev_p;
  logic [NCNT-1:0] occ_p;
  logic [NCNT-1:0] ovf_p;
  logic snap;
  tem_cnt_arr_t live_q;
  tem_cnt_arr_t snap_q;

  function automatic logic [3:0] ones10(input logic [CW_HIST-1:0] v);
    logic [3:0] c;
    c = 4'h0;
    for (int i = 0; i < CW_HIST; i++) begin
      c = c + {3'h0, v[i]};
    end
    ones10 = c;
  endfunction

  function automatic logic inj_hit(input int i, input tem_tx_t t, input logic e1);
    case (i)
      INJ_BPV: inj_hit = 1'b1;
      INJ_CRC: inj_hit = t.crc;
      INJ_FBIT: inj_hit = t.fbit;
      INJ_PAY: inj_hit = t.pay;
      INJ_EBIT: inj_hit = t.ebit && e1;
      INJ_NFAS: inj_hit = t.nfas && e1;
      default: inj_hit = 1'b0;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // Crossings
  // ---------------------------------------------------------------
  tem_sync #(.W(1)) u_rst_sync (.clk(lclk), .srst(1'b0), .d(srst), .q(lk_rst));
  tem_sync #(.W($bits(tem_cfg_t))) u_cfg_sync (.clk(lclk), .srst(lk_rst), .d(cfg), .q(cfg_lv));
  tem_sync #(.W(NINJ)) u_inj_sync (.clk(lclk), .srst(lk_rst), .d(sy_ff.inj_tgl), .q(inj_s));
  tem_sync #(.W(NCNT)) u_ev_sync (.clk(clk), .srst(srst), .d(lk_ff.ev_tgl), .q(ev_s));
  tem_sync #(.W($bits(tem_alm_t))) u_alm_sync (.clk(clk), .srst(srst), .d(lk_ff.alm), .q(alm_s));

  assign cfg_l = tem_cfg_t'(cfg_lv);

  // ---------------------------------------------------------------
  // Line side: alarm detection and error injection
  // ---------------------------------------------------------------
  always_comb begin
    nxt_lk = lk_ff;
    for (int i = 0; i < NCNT; i++) begin
      if (err_ev[i]) begin
        nxt_lk.ev_tgl[i] = ~lk_ff.ev_tgl[i];
      end
    end
    if (rx.vld) begin
      if (rx.bit_v) begin
        nxt_lk.zrun = 8'h00;
        nxt_lk.los = 1'b0;
      end else begin
        if (lk_ff.zrun != ZRUN_SAT) begin
          nxt_lk.zrun = lk_ff.zrun + 8'h01;
        end
        if (nxt_lk.zrun >= (cfg_l.los_short ? LOS_SHORT : LOS_LONG)) begin
          nxt_lk.los = 1'b1;
        end
      end
      if (!rx.fbit && rx.pos == POS_BIT2 && rx.bit_v && lk_ff.y_ones != YEL_SAT) begin
        nxt_lk.y_ones = lk_ff.y_ones + 4'h1;
      end
      if (!rx.bit_v && lk_ff.a_zero != AIS_MIN_ZEROS) begin
        nxt_lk.a_zero = lk_ff.a_zero + 3'h1;
      end
      if (!rx.bit_v) begin
        nxt_lk.d_zero = 1'b1;
      end
      if (rx.sof) begin
        nxt_lk.y_frm = lk_ff.y_frm + 9'h001;
        if (lk_ff.y_frm == YEL_WIN_FRM - 9'h001) begin
          nxt_lk.y_frm = 9'h000;
          nxt_lk.yel1 = lk_ff.y_ones <= YEL_ONES_MAX;
          nxt_lk.y_ones = 4'h0;
        end
        nxt_lk.a_frm = lk_ff.a_frm + 9'h001;
        if (lk_ff.a_frm == AIS_WIN_FRM - 9'h001) begin
          nxt_lk.a_frm = 9'h000;
          nxt_lk.ais_t1 = lk_ff.a_zero < AIS_MIN_ZEROS;
          nxt_lk.a_zero = {2'h0, ~rx.bit_v};
        end
        if (!rx.frm[0]) begin
          if (lk_ff.d_zero) begin
            nxt_lk.d_ok = 2'h0;
          end else if (lk_ff.d_ok != AIS_DF_TWO) begin
            nxt_lk.d_ok = lk_ff.d_ok + 2'h1;
          end
          nxt_lk.d_zero = ~rx.bit_v;
        end
      end
      if (rx.fbit && rx.frm == FRM_S12) begin
        nxt_lk.s12_prev = rx.bit_v;
        nxt_lk.yel2 = rx.bit_v && lk_ff.s12_prev;
      end
      if (rx.fbit && rx.dl) begin
        nxt_lk.cw_sr = {lk_ff.cw_sr[14:0], rx.bit_v};
        nxt_lk.cw_bits = lk_ff.cw_bits + 4'h1;
        if (lk_ff.cw_bits == CW_LAST) begin
          nxt_lk.cw_hist = {lk_ff.cw_hist[CW_HIST-2:0],
                            nxt_lk.cw_sr == (cfg_l.mode == TEM_J1ESF ? CW_J1 : CW_T1)};
          nxt_lk.yel_cw = ones10(nxt_lk.cw_hist) >= CW_MIN;
        end
      end
      if (!rx.fbit && rx.ts == TS_DM && rx.pos == POS_BIT2) begin
        nxt_lk.yel_dm = ~rx.bit_v;
      end
      if (rx.ts == TS0 && rx.frm[0] && rx.pos == POS_RAI) begin
        nxt_lk.rai = rx.bit_v;
      end
      if (rx.ts == TS16) begin
        if (rx.pos == POS_FIRST) begin
          nxt_lk.t16_z = ~rx.bit_v;
        end else if (!rx.bit_v) begin
          nxt_lk.t16_z = 1'b1;
        end
        if (rx.pos == POS_LAST) begin
          nxt_lk.t16_ais = ~nxt_lk.t16_z;
        end
        if (rx.frm == FRM_MFAS && rx.pos == POS_Y) begin
          nxt_lk.mfy = rx.bit_v;
        end
      end
    end
    // Injection: a command waits for the next matching bit, then is consumed.
    nxt_lk.tx.vld = tx_in.vld;
    nxt_lk.tx.bit_v = tx_in.bit_v;
    nxt_lk.tx.bpv = 1'b0;
    if (tx_in.vld) begin
      for (int i = 0; i < NINJ; i++) begin
        if (lk_ff.inj_pend[i] && inj_hit(i, tx_in, cfg_l.mode == TEM_E1)) begin
          nxt_lk.inj_pend[i] = 1'b0;
          if (i == INJ_BPV) begin
            nxt_lk.tx.bpv = 1'b1;
          end else begin
            nxt_lk.tx.bit_v = ~tx_in.bit_v;
          end
        end
      end
      if (tx_in.sof) begin
        nxt_lk.los_act = lk_ff.inj_pend[INJ_LOS];
        nxt_lk.inj_pend[INJ_LOS] = 1'b0;
      end
      if (nxt_lk.los_act) begin
        nxt_lk.tx.bit_v = 1'b0;
      end
    end
    // New commands are applied after the consume so that a set wins over a clear.
    for (int i = 0; i < NINJ; i++) begin
      if (inj_s[i] != lk_ff.inj_d[i]) begin
        nxt_lk.inj_pend[i] = 1'b1;
      end
    end
    nxt_lk.inj_d = inj_s;
    // Alarm selection by framing mode.
    case (cfg_l.mode)
      TEM_D4: nxt_lk.alm.yel = cfg_l.yel_s12 ? nxt_lk.yel2 : nxt_lk.yel1;
      TEM_ESF, TEM_J1ESF: nxt_lk.alm.yel = nxt_lk.yel_cw;
      TEM_T1DM: nxt_lk.alm.yel = nxt_lk.yel_dm;
      default: nxt_lk.alm.yel = 1'b0;
    endcase
    if (cfg_l.mode == TEM_E1) begin
      nxt_lk.alm.ais = nxt_lk.d_ok >= (cfg_l.ais_alt ? AIS_DF_TWO : AIS_DF_ONE);
    end else begin
      nxt_lk.alm.ais = nxt_lk.ais_t1;
    end
    nxt_lk.alm.los = nxt_lk.los;
    nxt_lk.alm.rai = nxt_lk.rai && cfg_l.mode == TEM_E1;
    nxt_lk.alm.ts16_ais = nxt_lk.t16_ais && cfg_l.mode == TEM_E1;
    nxt_lk.alm.mf_yel = nxt_lk.mfy && cfg_l.mode == TEM_E1;
  end

  always_ff @(posedge lclk) begin
    if (lk_rst) begin
      lk_ff <= '0;
    end else begin
      lk_ff <= nxt_lk;
    end
  end

  assign tx_out = lk_ff.tx;

  // ---------------------------------------------------------------
  // System side: counters, one-second latch and flags
  // ---------------------------------------------------------------
  assign ev_p = ev_s ^ sy_ff.ev_d;
  assign snap = cfg.latch_en && sy_ff.sec == 32'(SEC_CYC - 1);

  // The same nine counters serve T1/J1 and E1; only the event meaning changes.
  for (genvar g = 0; g < NCNT; g++) begin : g_cnt
    tem_cnt #(.W(cnt_w(g))) u_cnt (
      .clk(clk),
      .srst(srst),
      .inc(ev_p[g]),
      .wr(cnt_wr[g]),
      .wr_val(cnt_wr_val),
      .snap(snap),
      .q(live_q[g]),
      .q_snap(snap_q[g]),
      .occ(occ_p[g]),
      .ovf(ovf_p[g])
    );
    assign cnt_q[g] = cfg.latch_en ? snap_q[g] : live_q[g];
  end

  always_comb begin
    nxt_sy = sy_ff;
    nxt_sy.ev_d = ev_s;
    for (int i = 0; i < NINJ; i++) begin
      if (inj_req[i]) begin
        nxt_sy.inj_tgl[i] = ~sy_ff.inj_tgl[i];
      end
    end
    if (sy_ff.sec == 32'(SEC_CYC - 1)) begin
      nxt_sy.sec = 32'h0000_0000;
    end else begin
      nxt_sy.sec = sy_ff.sec + 32'h0000_0001;
    end
    nxt_sy.occ = (sy_ff.occ & ~occ_clr) | occ_p;
    nxt_sy.ovf = (sy_ff.ovf & ~ovf_clr) | ovf_p;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sy_ff <= '0;
    end else begin
      sy_ff <= nxt_sy;
    end
  end

  assign occ_flag = sy_ff.occ & ~occ_mask;
  assign ovf_flag = sy_ff.ovf & ~ovf_mask;
  assign alm = alm_s;

endmodule

// *** bench/tem_props.sv ***
module tem_props #(
  parameter int SEC_CYC = 50
) (
  // Clocks and reset
  input wire logic clk,
  input wire logic srst,
  input wire logic lclk,
  // Watched signals
  input wire tem_pkg::tem_cfg_t cfg,
  input wire tem_pkg::tem_tx_t tx_in,
  input wire tem_pkg::tem_txo_t tx_out,
  input wire logic [tem_pkg::NCNT-1:0] cnt_wr,
  input wire logic [tem_pkg::CNT_DW-1:0] cnt_wr_val,
  input wire tem_pkg::tem_cnt_arr_t cnt_q,
  input wire logic [tem_pkg::NCNT-1:0] occ_clr,
  input wire logic [tem_pkg::NCNT-1:0] occ_mask,
  input wire logic [tem_pkg::NCNT-1:0] ovf_mask,
  input wire logic [tem_pkg::NCNT-1:0] occ_flag,
  input wire logic [tem_pkg::NCNT-1:0] ovf_flag
);
  timeunit 1ns;
  timeprecision 100ps;
  import tem_pkg::*;
  int unsigned sec_ff;

  // ---------------------------------------------------------------
  // Second counter mirror
  // ---------------------------------------------------------------
  // The snapshot edge may sit one cycle either side of this mirror, so a margin is left around it.
  always_ff @(posedge clk) begin
    if (srst) begin
      sec_ff <= 0;
    end else begin
      sec_ff <= (sec_ff == SEC_CYC - 1) ? 0 : sec_ff + 1;
    end
  end

  sequence s_wr16;
    cnt_wr[2] && !cfg.latch_en;
  endsequence
  sequence s_shows16;
    cnt_q[2] == $past(cnt_wr_val);
  endsequence

  AST_WR16: assert property (@(posedge clk) disable iff (srst) s_wr16 |=> s_shows16)
    else $error("16-bit counter did not take the written value");
  AST_WR8: assert property (@(posedge clk) disable iff (srst)
    cnt_wr[0] && !cfg.latch_en |=> cnt_q[0] == {8'h00, $past(cnt_wr_val[7:0])})
    else $error("8-bit counter did not take the written value");
  AST_OCC_MASK: assert property (@(posedge clk) disable iff (srst) (occ_flag & occ_mask) == '0)
    else $error("masked occurrence flag is visible");
  AST_OVF_MASK: assert property (@(posedge clk) disable iff (srst) (ovf_flag & ovf_mask) == '0)
    else $error("masked overflow flag is visible");
  AST_OCC_CLR: assert property (@(posedge clk) disable iff (srst)
    $fell(occ_flag[0]) && !occ_mask[0] |-> $past(occ_clr[0]) || $past(occ_clr[0], 2))
    else $error("occurrence flag dropped without a clear");
  AST_RST: assert property (@(posedge clk) disable iff (srst)
    $past(srst) |-> cnt_q == '0 && occ_flag == '0 && ovf_flag == '0)
    else $error("counters or flags not zero after reset");
  AST_TX_VLD: assert property (@(posedge lclk) disable iff (srst) 1'b1 |=> tx_out.vld == $past(tx_in.vld))
    else $error("transmit valid not delayed by one line clock");
  AST_BPV: assert property (@(posedge lclk) disable iff (srst) tx_out.bpv |-> $past(tx_in.vld))
    else $error("violation request on an empty bit");
  AST_LATCH: assert property (@(posedge clk) disable iff (srst)
    cfg.latch_en && $past(cfg.latch_en) && $past(cnt_wr) == '0 && $past(sec_ff) inside {[2:SEC_CYC-3]}
    |-> $stable(cnt_q))
    else $error("latched counters moved between second marks");
endmodule

bind tem_alarm_mon tem_props #(.SEC_CYC(SEC_CYC)) tem_props_inst (.clk(clk), .srst(srst), .lclk(lclk),
  .cfg(cfg), .tx_in(tx_in), .tx_out(tx_out), .cnt_wr(cnt_wr), .cnt_wr_val(cnt_wr_val), .cnt_q(cnt_q),
  .occ_clr(occ_clr), .occ_mask(occ_mask), .ovf_mask(ovf_mask), .occ_flag(occ_flag), .ovf_flag(ovf_flag));

// *** bench/tem_line_model.sv ***
module tem_line_model (
  // Line clock
  input wire logic lclk,
  // Control from the bench
  input wire logic run,
  input wire logic [1:0] pat,
  // Streams towards the block
  output tem_pkg::tem_rx_t rx,
  output tem_pkg::tem_tx_t tx_in
);
  timeunit 1ns;
  timeprecision 100ps;
  import tem_pkg::*;
  logic [7:0] bit_ff;
  logic [3:0] frm_ff;

  // ---------------------------------------------------------------
  // Framed stream, 32 slots of 8 bits
  // ---------------------------------------------------------------
  // While stopped the data line toggles, so no stale level can pass for real data.
  initial begin
    rx = '0;
    tx_in = '0;
    bit_ff = '0;
    frm_ff = '0;
  end
  always @(posedge lclk) begin
    logic b;
    b = (pat == 2'h0) ? 1'($urandom) : pat[1];
    rx <= '{vld: run, bit_v: run ? b : !rx.bit_v, sof: bit_ff == 8'h00, fbit: 1'b0, dl: 1'b0,
      frm: frm_ff, ts: bit_ff[7:3], pos: bit_ff[2:0]};
    tx_in <= '{vld: run, bit_v: b, sof: bit_ff == 8'h00, fbit: bit_ff == 8'h00,
      crc: 1'b0, ebit: 1'b0, nfas: 1'b0, pay: bit_ff[7:3] != 5'h00};
    if (run) begin
      bit_ff <= bit_ff + 8'h01;
      frm_ff <= (bit_ff == 8'hFF) ? frm_ff + 4'h1 : frm_ff;
    end
  end
endmodule

// *** bench/testbench.sv ***
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import tem_pkg::*;
  localparam int SEC = 50;
  logic clk, lclk, srst, run;
  logic [1:0] pat;
  logic [8:0] set;
  tem_cfg_t cfg;
  tem_rx_t rx;
  tem_tx_t tx_in;
  tem_txo_t tx_out;
  tem_alm_t alm;
  tem_cnt_arr_t cnt_q;
  logic [NCNT-1:0] err_ev, cnt_wr, occ_clr, ovf_clr, occ_mask, ovf_mask, occ_flag, ovf_flag;
  logic [NINJ-1:0] inj_req;
  logic [15:0] wr_val;
  int num_errors, checks_done, bpv_seen, tx_flips;
  logic tx_prev_bit;
  int mdl[NCNT];

  tem_alarm_mon #(.SEC_CYC(SEC)) tem_alarm_mon_inst (.clk(clk), .srst(srst), .cfg(cfg), .lclk(lclk), .rx(rx),
    .err_ev(err_ev), .tx_in(tx_in), .tx_out(tx_out), .inj_req(inj_req), .cnt_wr(cnt_wr), .cnt_wr_val(wr_val),
    .cnt_q(cnt_q), .occ_clr(occ_clr), .ovf_clr(ovf_clr), .occ_mask(occ_mask), .ovf_mask(ovf_mask),
    .occ_flag(occ_flag), .ovf_flag(ovf_flag), .alm(alm));
  tem_line_model tem_line_model_inst (.lclk(lclk), .run(run), .pat(pat), .rx(rx), .tx_in(tx_in));

  // ---------------------------------------------------------------
  // Clocks, helpers and checks
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = !clk;
  end
  initial begin
    lclk = 1'b0;
    #3.3;
    forever #62.5 lclk = !lclk;
  end
  // Each transmit bit that leaves different from the bit that came in is one injected error.
  always @(posedge lclk) begin
    if (tx_out.bpv === 1'b1) bpv_seen++;
    if (tx_out.vld === 1'b1 && tx_out.bit_v !== tx_prev_bit) tx_flips++;
    tx_prev_bit <= tx_in.bit_v;
  end

  function automatic int wmax(int i);
    return (i >= 2 && i <= 5) ? 32'hFFFF : 32'hFF;
  endfunction
  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic lwait(int n);
    repeat (n) @(posedge lclk);
    repeat (4) @(posedge clk);
  endtask
  task automatic setcfg(tem_mode_t m, logic ls, logic le);
    @(posedge clk);
    cfg <= '{mode: m, los_short: ls, ais_alt: 1'b0, yel_s12: 1'b0, latch_en: le};
    lwait(4);
  endtask
  task automatic wr(int i, int v);
    @(posedge clk);
    cnt_wr[i] <= 1'b1;
    wr_val <= 16'(v);
    mdl[i] = v & wmax(i);
    @(posedge clk);
    // Writes leave the sticky flags alone, so the flag check sees every counter's events.
    cnt_wr <= '0;
    #1;
  endtask
  task automatic ev(int i);
    @(posedge lclk);
    err_ev[i] <= 1'b1;
    @(posedge lclk);
    err_ev <= '0;
    mdl[i] = (mdl[i] + 1) & wmax(i);
    repeat (10) @(posedge clk);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    // The line starts as all ones, so the first signalling multiframe carries the Y-bit alarm.
    {srst, run, pat, cfg} = {1'b1, 1'b0, 2'h2, 7'h00};
    {num_errors, checks_done, bpv_seen, tx_flips} = '0;
    {err_ev, cnt_wr, occ_clr, ovf_clr, occ_mask, ovf_mask, inj_req, wr_val} = '0;
    void'($urandom(88893));
    // Reset spans line clock edges too, since the line side only sees it through a synchroniser.
    repeat (8) @(posedge lclk);
    @(posedge clk);
    srst <= 1'b0;
    lwait(4);
    run <= 1'b1;
    foreach (mdl[i]) begin
      wr(i, $urandom);
      chk(cnt_q[i], mdl[i]);
    end
    $display("test done: write and preset");
    for (int m = 0; m < 2; m++) begin
      setcfg(m ? TEM_E1 : TEM_D4, 1'b0, 1'b0);
      set = m ? 9'h0FF : 9'h1FF;
      for (int i = 0; i < NCNT - m; i++) begin
        wr(i, wmax(i));
        ev(i);
        chk({cnt_q[i], occ_flag[i], ovf_flag[i]}, {mdl[i][15:0], 2'h3});
        ev(i);
        chk(cnt_q[i], mdl[i]);
      end
      @(posedge clk);
      {occ_mask, ovf_mask} <= {9'h1FF, 9'h0AA};
      @(posedge clk);
      #1;
      chk({occ_flag, ovf_flag}, {9'h000, set & 9'h155});
      @(posedge clk);
      {occ_mask, ovf_mask, occ_clr, ovf_clr} <= {18'h0, 18'h3FFFF};
      @(posedge clk);
      {occ_clr, ovf_clr} <= '0;
      @(posedge clk);
      #1;
      chk({occ_flag, ovf_flag}, 18'h0);
    end
    $display("test done: events and flags");
    setcfg(TEM_E1, 1'b1, 1'b0);
    pat <= 2'h2;
    lwait(1300);
    chk({alm.ais, alm.los, alm.rai, alm.ts16_ais, alm.mf_yel}, 5'b10111);
    pat <= 2'h1;
    lwait(20);
    chk(alm.los, 1'b0);
    lwait(20);
    chk(alm.los, 1'b1);
    pat <= 2'h2;
    setcfg(TEM_E1, 1'b0, 1'b0);
    pat <= 2'h1;
    lwait(150);
    chk(alm.los, 1'b0);
    lwait(60);
    chk(alm.los, 1'b1);
    setcfg(TEM_T1DM, 1'b0, 1'b0);
    lwait(300);
    chk(alm.yel, 1'b1);
    pat <= 2'h2;
    lwait(300);
    chk(alm.yel, 1'b0);
    $display("test done: alarms");
    // All-ones data makes every forced zero of a lost-signal frame countable.
    pat <= 2'h2;
    for (int k = 0; k < NINJ; k++) begin
      @(posedge clk);
      inj_req[k] <= 1'b1;
      @(posedge clk);
      inj_req <= '0;
      lwait(600);
    end
    chk(bpv_seen, 1);
    chk(tx_flips, 2 + 256);
    $display("test done: injection");
    wr(4, 5);
    setcfg(TEM_E1, 1'b0, 1'b1);
    ev(4);
    repeat (60) @(posedge clk);
    chk(cnt_q[4], mdl[4]);
    $display("test done: latch");
    give_verdict();
  end

  initial begin
    #1ms;
    num_errors++;
    give_verdict();
  end
endmodule
